// ===== logic/tc_cold_pkg.sv
// Package with register map, fields, timing and carrier types for the cold-state handshake
package tc_cold_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] MAILBOX_OFF      = 12'h000;
  localparam logic [11:0] HANDSHAKE_OFF    = 12'h004;
  localparam logic [11:0] LIVE_STATUS_OFF  = 12'h008;
  localparam logic [11:0] AUX_CTRL_OFF     = 12'h00C;
  localparam logic [11:0] HPD_CTRL_OFF     = 12'h010;
  localparam logic [11:0] RESOURCE_OFF     = 12'h014;
  localparam logic [11:0] STANDBY_OFF      = 12'h018;
  localparam logic [11:0] POWER_STATE_OFF  = 12'h01C;
  localparam logic [11:0] LANE_MUX_BASE    = 12'h100;
  localparam logic [11:0] LANE_MUX_MASK    = 12'hF00;

  // ---------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------
  localparam int          MB_BUSY_BIT      = 31;
  localparam logic [7:0]  MB_EXIT_COLD_CMD = 8'h12;
  localparam int          AUX_ALT_BIT      = 0;
  localparam int          AUX_TUN_BIT      = 1;
  localparam int          AUX_NAT_BIT      = 2;
  localparam int          FIXED_NATIVE_BIT = 3;

  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [31:0] ALL_ONES         = 32'hFFFF_FFFF;
  localparam logic [2:0]  HPD_EN_RST       = 3'h0;
  localparam int          CLK_MHZ          = 200;
  localparam int          EXIT_HOLD_MS     = 500;
  localparam int          EXIT_HOLD_CYCLES = EXIT_HOLD_MS * 1000 * CLK_MHZ + 1;
  localparam int          ACCEPT_CYCLES    = 2;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic tunnel;
    logic alt;
    logic native;
  } hpd_set_t;

  typedef enum logic [1:0] {
    OWN_FREE,
    OWN_IO_MANAGER,
    OWN_TUNNEL
  } owner_t;

endpackage

// ===== logic/tc_cold_handshake.sv
// Power-state and resource ownership handshake for a Type-C display subsystem
//
// Operation
// - Three independent hot plug sets, enable each
// - Live status reports tunnel and alt connections
// - Manager claim beats tunnel claim, forcing release
// - Acknowledge every tunnel disconnect message
// - Standby request causes unplug, release causes plug
// - Cold state: lane regs read ones, ignore writes
// - Leave cold on alt or tunnel connect or exit command
// - Aux request blocks entry, no exit, no ack
// - Alt mode re-entry needs disconnect and flag zero
// - Tunnel use holds off cold re-entry
// - Native re-entry once aux request clears
// - Exit command keeps warm over 500 ms
`timescale 1ns/1ps
`default_nettype none

module tc_cold_handshake
  import tc_cold_pkg::*;
#(
  parameter int EXIT_HOLD = EXIT_HOLD_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        alt_connect_in,
  input  wire logic        native_connect_in,
  input  wire logic        tunnel_hpd_msg_in,
  input  wire logic        tunnel_hpd_level_in,
  input  wire logic        tunnel_in_use_in,
  input  wire logic        tunnel_claim_in,
  input  wire logic        tunnel_release_in,
  output logic             tunnel_disc_ack_out,
  output logic      [1:0]  stream_owner_out,
  output logic             standby_unplug_request_out,
  output logic      [2:0]  hpd_event_out,
  output logic             aux_power_ack_out,
  output logic             subsystem_cold_state_out
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] sync1_r;
  logic [5:0] sync2_r;
  logic [5:0] sync_nxt;

  // Raw pins only: gating ahead of the first flop would mix unsynchronised levels
  assign sync_nxt = {alt_connect_in, native_connect_in, tunnel_hpd_msg_in,
                     tunnel_hpd_level_in, tunnel_in_use_in, tunnel_claim_in};

  logic rel_s1_r;
  logic rel_s2_r;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync1_r  <= 6'h00;
      sync2_r  <= 6'h00;
      rel_s1_r <= 1'b0;
      rel_s2_r <= 1'b0;
    end else begin
      sync1_r  <= sync_nxt;
      sync2_r  <= sync1_r;
      rel_s1_r <= tunnel_release_in;
      rel_s2_r <= rel_s1_r;
    end
  end

  wire alt_conn      = sync2_r[5];
  wire native_conn   = sync2_r[4];
  wire tun_msg       = sync2_r[3];
  wire tun_level     = sync2_r[2];
  wire tun_use       = sync2_r[1];
  // Claim seen together with release counts as no claim
  wire tun_claim     = sync2_r[0] && !rel_s2_r;
  wire tun_release   = rel_s2_r;

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic        cold_r;
  logic        mb_busy_r;
  logic [7:0]  mb_cmd_r;
  logic [1:0]  mb_wait_r;
  logic        safe_mode_exit_flag_r;
  logic [3:0]  aux_ctrl_r;
  hpd_set_t    hpd_en_r;
  logic        standby_r;
  logic        io_claim_r;
  owner_t      owner_r;
  logic [31:0] lane_mux_r;
  logic [31:0] hold_cnt_r;
  logic        msg_d_r;
  logic [2:0]  conn_d_r;
  logic        ack_r;
  logic [2:0]  hpd_ev_r;
  logic [31:0] prdata_r;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // Full-word address match shared by every register select except the masked lane-mux window
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  wire acc      = psel_in && penable_in;
  wire setup    = psel_in && !penable_in;
  wire wr       = acc && pwrite_in;
  wire is_lane  = (paddr_in & LANE_MUX_MASK) == LANE_MUX_BASE;
  wire hit_mb   = addr_is(paddr_in, MAILBOX_OFF);
  wire hit_hs   = addr_is(paddr_in, HANDSHAKE_OFF);
  wire hit_live = addr_is(paddr_in, LIVE_STATUS_OFF);
  wire hit_aux  = addr_is(paddr_in, AUX_CTRL_OFF);
  wire hit_hpd  = addr_is(paddr_in, HPD_CTRL_OFF);
  wire hit_res  = addr_is(paddr_in, RESOURCE_OFF);
  wire hit_stb  = addr_is(paddr_in, STANDBY_OFF);
  wire hit_pwr  = addr_is(paddr_in, POWER_STATE_OFF);
  wire mapped   = hit_mb | hit_hs | hit_live | hit_aux | hit_hpd | hit_res
                | hit_stb | hit_pwr | is_lane;

  // Lane-mux side registers are dead while cold
  wire lane_wr_ok = wr && !cold_r;
  wire mb_start   = wr && hit_mb && !mb_busy_r && pwdata_in[MB_BUSY_BIT];

  // ---------------------------------------------------------------
  // Cold-state decision
  // ---------------------------------------------------------------
  wire aux_req     = |aux_ctrl_r[2:0];
  wire fixed_nat   = aux_ctrl_r[FIXED_NATIVE_BIT];
  wire tun_busy    = tun_use || owner_r == OWN_TUNNEL;
  wire hold_active = hold_cnt_r != 32'h0;
  wire exit_accept = mb_busy_r && mb_wait_r == 2'(ACCEPT_CYCLES - 1)
                     && mb_cmd_r == MB_EXIT_COLD_CMD;
  wire any_conn    = alt_conn || tun_level;
  // Flag blocks re-entry only for alternate mode
  wire flag_block  = safe_mode_exit_flag_r && !fixed_nat;
  wire ports_idle  = !any_conn && !flag_block && !tun_busy
                     && !(fixed_nat && native_conn && aux_req);
  wire enter_cold  = !cold_r && ports_idle && !aux_req && !hold_active;
  wire leave_cold  = cold_r && (any_conn || exit_accept);

  // ---------------------------------------------------------------
  // Ownership
  // ---------------------------------------------------------------
  owner_t owner_nxt;
  assign owner_nxt = io_claim_r                     ? OWN_IO_MANAGER
                   : (owner_r == OWN_IO_MANAGER)    ? OWN_FREE
                   : tun_claim                      ? OWN_TUNNEL
                   : tun_release                    ? OWN_FREE
                   : owner_r;

  // Disconnect message edge and connect edges
  wire disc_msg = msg_d_r && !tun_msg;
  wire [2:0] conn_now = {tun_level, alt_conn, native_conn};
  wire [2:0] conn_chg = (conn_now ^ conn_d_r) & {hpd_en_r.tunnel, hpd_en_r.alt, hpd_en_r.native};

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  // Cold hides the lane-mux side words behind all ones
  logic [31:0] rd_data;
  assign rd_data =
      hit_mb   ? {mb_busy_r, 23'h0, mb_cmd_r}
    : is_lane  ? (cold_r ? ALL_ONES : lane_mux_r)
    : cold_r && (hit_hs || hit_live) ? ALL_ONES
    : hit_hs   ? {31'h0, safe_mode_exit_flag_r}
    : hit_live ? {29'h0, tun_level, alt_conn, native_conn}
    : hit_aux  ? {27'h0, aux_power_ack_out, aux_ctrl_r}
    : hit_hpd  ? {29'h0, hpd_en_r}
    : hit_res  ? {29'h0, io_claim_r, owner_r}
    : hit_stb  ? {31'h0, standby_r}
    : hit_pwr  ? {30'h0, hold_active, cold_r}
    : 32'h0;

  // ---------------------------------------------------------------
  // Sequential logic
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cold_r                <= 1'b0;
      mb_busy_r             <= 1'b0;
      mb_cmd_r              <= 8'h00;
      mb_wait_r             <= 2'h0;
      safe_mode_exit_flag_r <= 1'b0;
      aux_ctrl_r            <= 4'h0;
      hpd_en_r              <= HPD_EN_RST;
      standby_r             <= 1'b0;
      io_claim_r            <= 1'b0;
      owner_r               <= OWN_FREE;
      lane_mux_r            <= 32'h0;
      hold_cnt_r            <= 32'h0;
      msg_d_r               <= 1'b0;
      conn_d_r              <= 3'h0;
      ack_r                 <= 1'b0;
      hpd_ev_r              <= 3'h0;
      prdata_r              <= 32'h0;
    end else begin
      // Mailbox: args ignored, busy drops after acceptance
      if (mb_start) begin
        mb_busy_r <= 1'b1;
        mb_cmd_r  <= pwdata_in[7:0];
        mb_wait_r <= 2'h0;
      end else if (mb_busy_r) begin
        if (mb_wait_r == 2'(ACCEPT_CYCLES - 1)) begin
          mb_busy_r <= 1'b0;
        end else begin
          mb_wait_r <= mb_wait_r + 2'h1;
        end
      end
      // A repeated exit restarts the warm hold from the top
      if (exit_accept) begin
        hold_cnt_r <= 32'(EXIT_HOLD);
      end else if (hold_active) begin
        hold_cnt_r <= hold_cnt_r - 32'h1;
      end
      if (leave_cold) begin
        cold_r <= 1'b0;
      end else if (enter_cold) begin
        cold_r <= 1'b1;
      end
      if (lane_wr_ok && hit_hs) begin
        safe_mode_exit_flag_r <= pwdata_in[0];
      end
      if (lane_wr_ok && is_lane) begin
        lane_mux_r <= pwdata_in;
      end
      if (wr && hit_aux) begin
        aux_ctrl_r <= pwdata_in[3:0];
      end
      if (wr && hit_hpd) begin
        hpd_en_r <= pwdata_in[2:0];
      end
      if (wr && hit_res) begin
        io_claim_r <= pwdata_in[2];
      end
      if (wr && hit_stb) begin
        standby_r <= pwdata_in[0];
      end
      owner_r    <= owner_nxt;
      msg_d_r    <= tun_msg;
      ack_r      <= disc_msg;
      conn_d_r   <= conn_now;
      hpd_ev_r   <= conn_chg;
      // Captured in setup so the word stands through the access cycle
      if (setup) begin
        prdata_r <= pwrite_in ? 32'h0 : rd_data;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic pready_r;
  logic pslverr_r;
  logic aux_ack_r;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      aux_ack_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      pslverr_r <= setup && !mapped;
      aux_ack_r <= aux_req && !cold_r;
    end
  end

  // pready rises one cycle after setup, so access phase is one cycle
  assign prdata_out                 = prdata_r;
  assign pready_out                 = pready_r;
  assign pslverr_out                = pslverr_r;
  assign tunnel_disc_ack_out        = ack_r;
  assign stream_owner_out           = owner_r;
  assign standby_unplug_request_out = standby_r;
  assign hpd_event_out              = hpd_ev_r;
  assign aux_power_ack_out          = aux_ack_r;
  assign subsystem_cold_state_out   = cold_r;

endmodule

`default_nettype wire

// ===== test/tc_cold_checker.sv
// Port-level assertions for the cold-state handshake block
`timescale 1ns/1ps
`default_nettype none
module tc_cold_checker
  import tc_cold_pkg::*;
#(
  parameter int EXIT_HOLD = EXIT_HOLD_CYCLES
) (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        alt_connect_in,
  input wire logic        tunnel_hpd_msg_in,
  input wire logic        tunnel_disc_ack_out,
  input wire logic [1:0]  stream_owner_out,
  input wire logic        standby_unplug_request_out,
  input wire logic        aux_power_ack_out,
  input wire logic        subsystem_cold_state_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // ---------------------------------------------------------------
  // Decoded transfers
  // ---------------------------------------------------------------
  wire acc_w  = psel_in && penable_in && pready_out;
  wire wr_w   = acc_w && pwrite_in;
  wire lane_w = (paddr_in & LANE_MUX_MASK) == LANE_MUX_BASE;
  wire exit_w = wr_w && paddr_in == MAILBOX_OFF && pwdata_in[MB_BUSY_BIT]
                && pwdata_in[7:0] == MB_EXIT_COLD_CMD;
  chk_ack_warm: assert property (aux_power_ack_out |-> !subsystem_cold_state_out)
    else $error("aux ack high while cold");
  chk_cold_ones: assert property (acc_w && !pwrite_in && lane_w && $past(subsystem_cold_state_out)
    |-> prdata_out == ALL_ONES) else $error("lane read while cold not all ones");
  chk_exit_warm: assert property (exit_w |-> ##[1:4] !subsystem_cold_state_out
    ##1 !subsystem_cold_state_out [*8]) else $error("exit command did not hold warm");
  chk_disc_ack: assert property ($fell(tunnel_hpd_msg_in) |-> ##[2:8] tunnel_disc_ack_out)
    else $error("disconnect message not acknowledged");
  chk_ack_single: assert property (tunnel_disc_ack_out |=> !tunnel_disc_ack_out)
    else $error("acknowledge longer than one cycle");
  chk_unplug_req: assert property ($changed(standby_unplug_request_out)
    |-> $past(wr_w && paddr_in == STANDBY_OFF) && $past(pwdata_in[0]) == standby_unplug_request_out)
    else $error("standby request changed without write");
  chk_io_claim: assert property (wr_w && paddr_in == RESOURCE_OFF && pwdata_in[2]
    |-> ##[1:3] stream_owner_out == OWN_IO_MANAGER) else $error("manager claim not granted");
  chk_alt_warm: assert property (alt_connect_in [*8] |-> !subsystem_cold_state_out)
    else $error("cold while receiver connected");
  cov_exit: cover property (exit_w);
  cov_ack: cover property (tunnel_disc_ack_out);
  cov_lane: cover property (acc_w && lane_w && subsystem_cold_state_out);
endmodule
bind tc_cold_handshake tc_cold_checker #(.EXIT_HOLD(EXIT_HOLD)) chk_i (
  .clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .prdata_out, .pready_out, .alt_connect_in, .tunnel_hpd_msg_in, .tunnel_disc_ack_out,
  .stream_owner_out, .standby_unplug_request_out, .aux_power_ack_out, .subsystem_cold_state_out
);
`default_nettype wire

// ===== test/tunnel_ctrl_model.sv
// Behavioural tunnelling controller facing the handshake block
`timescale 1ns/1ps
`default_nettype none
module tunnel_ctrl_model
  import tc_cold_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       plug_in,
  input  wire logic       standby_in,
  input  wire logic [1:0] owner_in,
  output logic            claim_out,
  output logic            release_out,
  output logic            in_use_out,
  output logic            hpd_level_out,
  output logic            hpd_msg_out
);
  wire want_w = plug_in && !standby_in;
  wire have_w = owner_in == OWN_TUNNEL;
  initial begin
    {claim_out, release_out, in_use_out, hpd_level_out, hpd_msg_out} = 5'h0;
  end
  // Yields the resource when the manager claims it; link and messages need ownership
  always @(posedge clk_in) begin
    claim_out     <= want_w && owner_in != OWN_IO_MANAGER;
    release_out   <= !want_w || owner_in == OWN_IO_MANAGER;
    in_use_out    <= want_w && have_w;
    hpd_level_out <= want_w && have_w;
    hpd_msg_out   <= want_w && have_w;
  end
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Self-checking bench for the cold-state handshake block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tc_cold_pkg::*;
;
  localparam int HOLD = 50;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        alt_c = 1'b0, nat_c = 1'b0, plug = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, ack, sreq, aux_ack, cold, t_clm, t_rel, t_use, t_lvl, t_msg;
  logic [1:0]  owner;
  logic [2:0]  hev;
  int          fails = 0, total_checks = 0, ack_n = 0, ev_n [3] = '{0, 0, 0};
  always #2.5 clk_in = ~clk_in;
  tc_cold_handshake #(.EXIT_HOLD(HOLD)) DUT (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .alt_connect_in(alt_c),
    .native_connect_in(nat_c), .tunnel_hpd_msg_in(t_msg), .tunnel_hpd_level_in(t_lvl),
    .tunnel_in_use_in(t_use), .tunnel_claim_in(t_clm), .tunnel_release_in(t_rel),
    .tunnel_disc_ack_out(ack), .stream_owner_out(owner), .standby_unplug_request_out(sreq),
    .hpd_event_out(hev), .aux_power_ack_out(aux_ack), .subsystem_cold_state_out(cold));
  tunnel_ctrl_model far_i (.clk_in(clk_in), .plug_in(plug), .standby_in(sreq), .owner_in(owner),
    .claim_out(t_clm), .release_out(t_rel), .in_use_out(t_use), .hpd_level_out(t_lvl),
    .hpd_msg_out(t_msg));
  always @(posedge clk_in) begin
    if (ack === 1'b1) ack_n++;
    for (int i = 0; i < 3; i++) if (hev[i] === 1'b1) ev_n[i]++;
  end
  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask
  task automatic settle(input bit own, input logic [1:0] v);
    int n;
    n = 0;
    while ((own ? owner : {1'b0, cold}) !== v && n < 300) begin
      @(posedge clk_in);
      n++;
    end
    chk(32'(own ? owner : {1'b0, cold}), 32'(v));
  endtask
  task automatic exit_cold();
    logic [31:0] q;
    logic e;
    int n;
    wr(MAILBOX_OFF, 32'h80AB_CD12);
    n = 0;
    do begin
      apb(1'b0, MAILBOX_OFF, 32'h0, q, e);
      n++;
    end while (q[MB_BUSY_BIT] !== 1'b0 && n < 10);
    chk(32'(q[MB_BUSY_BIT]), 32'h0);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd(HPD_CTRL_OFF, 32'(HPD_EN_RST));
    apb(1'b0, 12'h020, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    wr(HPD_CTRL_OFF, 32'h7);
  endtask
  task automatic t_cold_exit();
    settle(1'b0, 2'h1);
    wr(LANE_MUX_BASE, 32'h1234_5678);
    rd(LANE_MUX_BASE, ALL_ONES);
    rd(HANDSHAKE_OFF, ALL_ONES);
    exit_cold();
    chk(32'(cold), 32'h0);
    wr(LANE_MUX_BASE, 32'hA5A5_0001);
    rd(LANE_MUX_BASE, 32'hA5A5_0001);
    repeat (HOLD - 25) @(posedge clk_in);
    chk(32'(cold), 32'h0);
    settle(1'b0, 2'h1);
  endtask
  task automatic t_native();
    wr(AUX_CTRL_OFF, 32'h4);
    repeat (10) @(posedge clk_in);
    chk(32'({aux_ack, cold}), 32'h1);
    exit_cold();
    wr(HANDSHAKE_OFF, 32'h1);
    wr(AUX_CTRL_OFF, 32'hC);
    repeat (HOLD + 20) @(posedge clk_in);
    chk(32'({aux_ack, cold}), 32'h2);
    wr(AUX_CTRL_OFF, 32'h8);
    settle(1'b0, 2'h1);
    exit_cold();
    wr(HANDSHAKE_OFF, 32'h0);
    wr(AUX_CTRL_OFF, 32'h0);
    settle(1'b0, 2'h1);
  endtask
  task automatic t_alt();
    alt_c <= 1'b1;
    settle(1'b0, 2'h0);
    rd(LIVE_STATUS_OFF, 32'h2);
    wr(AUX_CTRL_OFF, 32'h1);
    rd(AUX_CTRL_OFF, 32'h11);
    wr(AUX_CTRL_OFF, 32'h0);
    wr(HANDSHAKE_OFF, 32'h1);
    nat_c <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk(32'({ev_n[2][7:0], ev_n[1][7:0], ev_n[0][7:0]}), 32'h0_0101);
    nat_c <= 1'b0;
    alt_c <= 1'b0;
    repeat (HOLD + 20) @(posedge clk_in);
    chk(32'(cold), 32'h0);
    rd(HANDSHAKE_OFF, 32'h1);
    wr(HANDSHAKE_OFF, 32'h0);
    settle(1'b0, 2'h1);
  endtask
  task automatic t_tunnel();
    plug <= 1'b1;
    settle(1'b1, OWN_TUNNEL);
    settle(1'b0, 2'h0);
    rd(LIVE_STATUS_OFF, 32'h4);
    wr(AUX_CTRL_OFF, 32'h2);
    rd(AUX_CTRL_OFF, 32'h12);
    wr(AUX_CTRL_OFF, 32'h0);
    chk(32'(ev_n[2]), 32'h1);
    wr(STANDBY_OFF, 32'h1);
    repeat (12) @(posedge clk_in);
    chk(32'({sreq, 8'(ack_n)}), 32'h101);
    wr(STANDBY_OFF, 32'h0);
    settle(1'b1, OWN_TUNNEL);
    repeat (HOLD + 20) @(posedge clk_in);
    chk(32'(cold), 32'h0);
    wr(RESOURCE_OFF, 32'h4);
    repeat (12) @(posedge clk_in);
    chk(32'({owner, 8'(ack_n)}), 32'h102);
    plug <= 1'b0;
    wr(RESOURCE_OFF, 32'h0);
    settle(1'b0, 2'h1);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_regs();
    t_cold_exit();
    t_native();
    t_alt();
    t_tunnel();
    stop_test();
  end
  initial begin
    #100000;
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
